// ---- verilog/teiu_top.sv ----
// Purpose: Two timers, overflow flags and single-level vectored interrupt unit
// Assumes: Instruction strobes are one-cycle pulses from the sequencer on mclk
// Notes: Pins irq_pin and t_pin_in are synchronised; results are registered
`include "teiu_consts.svh"
`timescale 1ns/100ps
module teiu_top #(
  parameter int PRESC_LONG_CYC = `TEIU_PRESC_LONG_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic irq_pin,
  input wire logic t_pin_in,
  input wire logic irq_allow_instruction,
  input wire logic irq_block_instruction,
  input wire logic irq_return_instruction,
  input wire logic call_instr,
  input wire logic ret_instr,
  input wire logic [10:0] pc_in,
  input wire logic [1:0] skip_state_in,
  input wire logic ctl_v_write,
  input wire logic ctl_w_write,
  input wire logic [3:0] ctl_data,
  input wire logic [7:0] ab_in,
  input wire logic load_first_timer,
  input wire logic read_first_timer,
  input wire logic read_second_timer,
  input wire logic load_reload_value,
  input wire logic read_reload_value,
  input wire logic skip_on_first_overflow,
  input wire logic skip_on_second_overflow,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic skip_result,
  output logic irq_taken,
  output logic [10:0] irq_vector,
  output logic [10:0] return_pc,
  output logic return_valid,
  output logic [1:0] skip_state_out,
  output logic [1:0] stack_depth,
  output logic irq_allow_flag,
  output logic t_pin_out,
  output logic t_pin_oe
);
  localparam int SHORT_CYC = `TEIU_PRESC_SHORT_CYC;

  logic [3:0] ctl_v;
  logic [3:0] ctl_w;
  logic external_irq_pending;
  logic first_timer_overflow_flag;
  logic second_timer_overflow_flag;
  logic [7:0] reload_reg;
  logic [14:0] presc;
  logic [10:0] stk [0:2];
  logic [1:0] skip_saved;
  logic irq_sync;
  logic irq_prev;
  logic t_sync;
  logic t_prev;
  logic [7:0] t1_count;
  logic [7:0] t2_count;
  logic t1_ovf;
  logic t2_ovf;

  // Control decode
  wire run1 = ctl_v[`TEIU_V_RUN1];
  wire run2 = ctl_v[`TEIU_V_RUN2];
  wire irq1_en = ctl_v[`TEIU_V_IRQ1];
  wire irq2_en = ctl_v[`TEIU_V_IRQ2];
  wire src1_t2 = ctl_w[`TEIU_W_SRC1];
  wire src2_pin = ctl_w[`TEIU_W_SRC2];
  wire psel_long = ctl_w[`TEIU_W_PSEL];
  wire gate_en = ctl_w[`TEIU_W_GATE];

  // Prescaler; the long period is a parameter so simulation can shorten it
  wire [14:0] presc_last = psel_long ? 15'(PRESC_LONG_CYC - 1) : 15'(SHORT_CYC - 1);
  wire presc_tick = (presc >= presc_last);

  // Pin edges, read only from the second synchroniser stage
  wire irq_rise = irq_sync && !irq_prev;
  wire t_rise = t_sync && !t_prev;

  // Count sources
  wire t1_tick = run1 && !first_timer_overflow_flag &&
    (src1_t2 ? t2_ovf : presc_tick);
  wire t2_pin_go = run2 || (run1 && gate_en);
  wire t2_tick = src2_pin ? (t_rise && t2_pin_go) : (presc_tick && run2);

  // Interrupt selection, external first
  wire pend_t1 = first_timer_overflow_flag && irq1_en;
  wire pend_t2 = second_timer_overflow_flag && irq2_en;
  wire pend_any = external_irq_pending || pend_t1 || pend_t2;
  wire take = irq_allow_flag && pend_any;
  wire take_ext = take && external_irq_pending;
  wire take_t1 = take && !external_irq_pending && pend_t1;
  wire take_t2 = take && !external_irq_pending && !pend_t1;
  teiu_pkg::teiu_cause_t cause;
  assign cause = take_ext ? teiu_pkg::TEIU_CAUSE_EXT :
    take_t1 ? teiu_pkg::TEIU_CAUSE_T1 : teiu_pkg::TEIU_CAUSE_T2;
  logic [10:0] vec_sel;
  always_comb begin
    case (cause)
      teiu_pkg::TEIU_CAUSE_EXT: vec_sel = `TEIU_VEC_EXT;
      teiu_pkg::TEIU_CAUSE_T1: vec_sel = `TEIU_VEC_T1;
      teiu_pkg::TEIU_CAUSE_T2: vec_sel = `TEIU_VEC_T2;
      default: vec_sel = `TEIU_PC_ZERO;
    endcase
  end

  // Flag next values: a set in the clearing cycle wins, except a take clears the allow flag over an allow strobe
  wire clr1 = take_t1 || skip_on_first_overflow;
  wire clr2 = take_t2 || skip_on_second_overflow;
  wire next_flag1 = t1_ovf || (first_timer_overflow_flag && !clr1);
  wire next_flag2 = t2_ovf || (second_timer_overflow_flag && !clr2);
  wire next_ext = irq_rise || (external_irq_pending && !take_ext);
  wire next_allow = take ? 1'b0 :
    irq_allow_instruction ? 1'b1 : irq_block_instruction ? 1'b0 : irq_allow_flag;

  // Return stack
  wire push = call_instr || take;
  wire pop = (ret_instr || irq_return_instruction) && !push;
  wire [1:0] next_depth = (push && stack_depth != `TEIU_STACK_DEPTH) ? stack_depth + 2'h1 :
    (pop && stack_depth != 2'h0) ? stack_depth - 2'h1 : stack_depth;

  // Read mux
  wire rd_any = read_first_timer || read_second_timer || read_reload_value;
  wire [7:0] rd_sel = read_first_timer ? t1_count :
    read_second_timer ? t2_count : reload_reg;

  teiu_sync u_irq_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(irq_pin),
    .pin_sync(irq_sync)
  );

  teiu_sync u_t_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(t_pin_in),
    .pin_sync(t_sync)
  );

  teiu_cnt8 u_timer1 (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(t1_tick),
    .load(load_first_timer),
    .load_val(ab_in),
    .reload_en(1'b0),
    .reload_val(`TEIU_BYTE_ZERO),
    .count(t1_count),
    .ovf(t1_ovf)
  );

  teiu_cnt8 u_timer2 (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(t2_tick),
    .load(1'b0),
    .load_val(`TEIU_BYTE_ZERO),
    .reload_en(1'b1),
    .reload_val(reload_reg),
    .count(t2_count),
    .ovf(t2_ovf)
  );

  // Control, flags and prescaler
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl_v <= `TEIU_CTL_RESET;
      ctl_w <= `TEIU_CTL_RESET;
      external_irq_pending <= 1'b0;
      first_timer_overflow_flag <= 1'b0;
      second_timer_overflow_flag <= 1'b0;
      irq_allow_flag <= 1'b0;
      reload_reg <= `TEIU_BYTE_ZERO;
      presc <= 15'h0000;
      irq_prev <= 1'b0;
      t_prev <= 1'b0;
    end else begin
      ctl_v <= ctl_v_write ? ctl_data : ctl_v;
      ctl_w <= ctl_w_write ? ctl_data : ctl_w;
      external_irq_pending <= next_ext;
      first_timer_overflow_flag <= next_flag1;
      second_timer_overflow_flag <= next_flag2;
      irq_allow_flag <= next_allow;
      reload_reg <= load_reload_value ? ab_in : reload_reg;
      presc <= presc_tick ? 15'h0000 : presc + 15'h0001;
      irq_prev <= irq_sync;
      t_prev <= t_sync;
    end
  end

  // Interrupt entry, stack and skip-state save
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_taken <= 1'b0;
      irq_vector <= `TEIU_PC_ZERO;
      stack_depth <= 2'h0;
      return_pc <= `TEIU_PC_ZERO;
      return_valid <= 1'b0;
      skip_saved <= 2'h0;
      skip_state_out <= 2'h0;
      stk[0] <= `TEIU_PC_ZERO;
      stk[1] <= `TEIU_PC_ZERO;
      stk[2] <= `TEIU_PC_ZERO;
    end else begin
      irq_taken <= take;
      irq_vector <= take ? vec_sel : irq_vector;
      stack_depth <= next_depth;
      return_valid <= pop;
      return_pc <= pop ? stk[0] : return_pc;
      skip_saved <= take ? skip_state_in : skip_saved;
      skip_state_out <= irq_return_instruction ? skip_saved : skip_state_out;
      if (push) begin
        stk[0] <= pc_in;
        stk[1] <= stk[0];
        stk[2] <= stk[1];
      end else if (pop) begin
        stk[0] <= stk[1];
        stk[1] <= stk[2];
      end
    end
  end

  // Register reads, skip tests and timer pin
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_data <= `TEIU_BYTE_ZERO;
      rd_valid <= 1'b0;
      skip_result <= 1'b0;
      t_pin_out <= 1'b0;
      t_pin_oe <= 1'b1;
    end else begin
      rd_data <= rd_any ? rd_sel : rd_data;
      rd_valid <= rd_any;
      skip_result <= skip_on_first_overflow ? first_timer_overflow_flag :
        skip_on_second_overflow ? second_timer_overflow_flag : 1'b0;
      t_pin_out <= t2_ovf && !src2_pin;
      t_pin_oe <= !src2_pin;
    end
  end

  // Checks
  sequence s_t1_ovf_seen;
    t1_ovf;
  endsequence
  sequence s_t1_halted;
    first_timer_overflow_flag && (t1_count == `TEIU_BYTE_ZERO);
  endsequence

  property p_ext_vector;
    @(posedge mclk) disable iff (!reset_n)
      take_ext |=> irq_taken && (irq_vector == `TEIU_VEC_EXT);
  endproperty
  a_ext_vector: assert property (p_ext_vector) else $error("bad external vector");

  property p_t2_vector;
    @(posedge mclk) disable iff (!reset_n)
      take_t2 |=> irq_vector == `TEIU_VEC_T2;
  endproperty
  a_t2_vector: assert property (p_t2_vector) else $error("bad timer 2 vector");

  property p_taken_needs_allow;
    @(posedge mclk) disable iff (!reset_n)
      irq_taken |-> $past(irq_allow_flag) && !irq_allow_flag;
  endproperty
  a_taken_needs_allow: assert property (p_taken_needs_allow) else $error("taken while blocked");

  property p_pending_fires;
    @(posedge mclk) disable iff (!reset_n)
      (external_irq_pending && !irq_allow_flag) ##1 irq_allow_flag |=> irq_taken;
  endproperty
  a_pending_fires: assert property (p_pending_fires) else $error("pending cause lost");

  property p_push_pc;
    @(posedge mclk) disable iff (!reset_n)
      take |=> stk[0] == $past(pc_in);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pc not pushed");

  // Return alone must never reopen interrupts; only the allow strobe does
  property p_return_keeps_blocked;
    @(posedge mclk) disable iff (!reset_n)
      (irq_return_instruction && !irq_allow_instruction && !irq_allow_flag) |=> !irq_allow_flag;
  endproperty
  a_return_keeps_blocked: assert property (p_return_keeps_blocked) else $error("return reopened irq");

  property p_stays_blocked;
    @(posedge mclk) disable iff (!reset_n)
      (!irq_allow_flag && !irq_allow_instruction) |=> !irq_allow_flag;
  endproperty
  a_stays_blocked: assert property (p_stays_blocked) else $error("allow flag set alone");

  property p_t1_halt;
    @(posedge mclk) disable iff (!reset_n)
      s_t1_ovf_seen ##1 (!load_first_timer && !skip_on_first_overflow && !take_t1) [*2]
        |-> s_t1_halted;
  endproperty
  a_t1_halt: assert property (p_t1_halt) else $error("timer 1 kept counting");

  property p_t2_reload;
    @(posedge mclk) disable iff (!reset_n)
      t2_ovf |=> second_timer_overflow_flag && (t2_count == $past(reload_reg));
  endproperty
  a_t2_reload: assert property (p_t2_reload) else $error("timer 2 not reloaded");

  property p_skip_clears;
    @(posedge mclk) disable iff (!reset_n)
      (skip_on_second_overflow && !t2_ovf) |=> !second_timer_overflow_flag;
  endproperty
  a_skip_clears: assert property (p_skip_clears) else $error("flag not consumed");

  property p_pin_pulse;
    @(posedge mclk) disable iff (!reset_n)
      (t2_ovf && !src2_pin) |=> t_pin_out && t_pin_oe ##1 !t_pin_out || $past(t2_ovf);
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("no timer pin pulse");

  property p_depth_limit;
    @(posedge mclk) disable iff (!reset_n)
      (stack_depth == `TEIU_STACK_DEPTH && push) |=> stack_depth == `TEIU_STACK_DEPTH;
  endproperty
  a_depth_limit: assert property (p_depth_limit) else $error("stack depth wrong");

  property p_t1_vector;
    @(posedge mclk) disable iff (!reset_n)
      take_t1 |=> irq_taken && (irq_vector == `TEIU_VEC_T1);
  endproperty
  a_t1_vector: assert property (p_t1_vector) else $error("bad timer 1 vector");

  property p_skip_result;
    @(posedge mclk) disable iff (!reset_n)
      skip_on_first_overflow |=> skip_result == $past(first_timer_overflow_flag);
  endproperty
  a_skip_result: assert property (p_skip_result) else $error("bad skip result");

  // Reset itself is checked here, so no disable clause
  property p_reset_state;
    @(posedge mclk)
      !reset_n |=> !irq_allow_flag && !external_irq_pending && t_pin_oe && !t_pin_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
endmodule : teiu_top

// ---- verilog/teiu_consts.svh ----
// Purpose: Named constants for the timer, event and interrupt unit
// Assumes: 20 MHz mclk, instruction strobes are one-cycle pulses
// Notes: Control nibble layouts are fixed here and used by the top
// Functional notes
// - External pin rising edge requests an interrupt vectored to page 1 address 0.
// - Timer 1 overflow vectors to page 1 address 2, timer 2 to address 4.
// - Interrupts taken only while allow flag is 1; allow sets, block clears.
// - A cause held while blocked fires once the allow flag returns to 1.
// - Taking an interrupt pushes the program counter and loads the vector.
// - Taking clears allow flag; it stays clear after return until allow.
// - Return stack holds three levels; interrupt uses one, leaving two for calls.
// - Each skip flag state is saved on interrupt entry and restored on return.
// - Each timer overflow either interrupts or is polled by a skip test.
// - Timer 1 is an 8-bit counter loaded from and read into the pair.
// - Control bits start timer 1 and pick prescaler or timer 2 overflow.
// - Timer 1 overflow sets its flag and halts timer 1.
// - Timer 2 is 8-bit with reload register; counter and reload are readable.
// - Control bits start timer 2 and pick prescaler or external timer pin.
// - Pin-sourced timer 2 is gated by enable bit while only timer 1 runs.
// - Timer 2 overflow sets its flag, reloads, and keeps counting.
// - Overflow flags clear when consumed by interrupt or skip test.
// - Reset clears control registers, all flags, allow flag, and drives pin low.
// - Timer pin pulses on each timer 2 overflow when not the count source.
`ifndef TEIU_CONSTS_SVH
`define TEIU_CONSTS_SVH
`define TEIU_CLK_MHZ 20
`define TEIU_PRESC_SHORT_US 160
`define TEIU_PRESC_LONG_US 1270
`define TEIU_PRESC_SHORT_CYC (`TEIU_PRESC_SHORT_US * `TEIU_CLK_MHZ)
`define TEIU_PRESC_LONG_CYC (`TEIU_PRESC_LONG_US * `TEIU_CLK_MHZ)
`define TEIU_VEC_EXT 11'h080
`define TEIU_VEC_T1 11'h082
`define TEIU_VEC_T2 11'h084
`define TEIU_CTL_RESET 4'h0
`define TEIU_BYTE_ZERO 8'h00
`define TEIU_BYTE_ONES 8'hFF
`define TEIU_PC_ZERO 11'h000
`define TEIU_STACK_DEPTH 2'h3
// Control nibble v
`define TEIU_V_RUN1 0
`define TEIU_V_RUN2 1
`define TEIU_V_IRQ1 2
`define TEIU_V_IRQ2 3
// Control nibble w
`define TEIU_W_SRC1 0
`define TEIU_W_SRC2 1
`define TEIU_W_PSEL 2
`define TEIU_W_GATE 3
`endif

// ---- verilog/teiu_pkg.sv ----
// Purpose: Types for the timer, event and interrupt unit
// Assumes: Nothing beyond the consts header
// Notes: Cause codes are one-hot
package teiu_pkg;
  typedef enum logic [2:0] {
    TEIU_CAUSE_EXT = 3'h1,
    TEIU_CAUSE_T1 = 3'h2,
    TEIU_CAUSE_T2 = 3'h4
  } teiu_cause_t;
  typedef enum logic [1:0] {
    TEIU_RD_T1 = 2'h1,
    TEIU_RD_T2 = 2'h2
  } teiu_rd_t;
endpackage : teiu_pkg

// ---- verilog/teiu_sync.sv ----
// Purpose: Two-stage synchroniser for one pin
// Assumes: Pin is asynchronous to mclk
// Notes: Only the second stage is visible
`timescale 1ns/100ps
module teiu_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pin,
  output logic pin_sync
);
  logic meta;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta <= pin;
      pin_sync <= meta;
    end
  end
endmodule : teiu_sync

// ---- verilog/teiu_cnt8.sv ----
// Purpose: 8-bit up-counter with load and optional auto-reload
// Assumes: tick is a one-cycle count event
// Notes: ovf is combinational so the caller sees it in the counting cycle
`include "teiu_consts.svh"
`timescale 1ns/100ps
module teiu_cnt8 (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic reload_en,
  input wire logic [7:0] reload_val,
  output logic [7:0] count,
  output logic ovf
);
  logic [7:0] next_count;

  assign ovf = tick && (count == `TEIU_BYTE_ONES);
  assign next_count = load ? load_val :
    (ovf && reload_en) ? reload_val :
    tick ? count + 8'h01 : count;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count <= `TEIU_BYTE_ZERO;
    end else begin
      count <= next_count;
    end
  end
endmodule : teiu_cnt8

// ---- dv/teiu_pin_src.sv ----
// Purpose: Outside event source for the interrupt pin and the timer pin
// Assumes: Requests are one-cycle pulses from the bench on mclk
// Notes: Pulses last HOLD cycles; the timer pin is shared with the unit
`timescale 1ns/100ps
module teiu_pin_src #(
  parameter int HOLD = 4
) (
  input wire logic mclk,
  input wire logic ext_req,
  input wire logic t_req,
  input wire logic t_pin_oe,
  input wire logic t_pin_out,
  output logic irq_pin,
  output logic t_pin_in
);
  int ext_left = 0;
  int t_left = 0;
  logic t_drive;
  // Pulses outlast the two-stage synchroniser, so no edge is lost
  always @(posedge mclk) begin
    if (ext_req) begin
      ext_left <= HOLD;
    end else if (ext_left > 0) begin
      ext_left <= ext_left - 1;
    end
    if (t_req) begin
      t_left <= HOLD;
    end else if (t_left > 0) begin
      t_left <= t_left - 1;
    end
  end
  assign irq_pin = (ext_left > 0);
  assign t_drive = (t_left > 0);
  // Unit owns the shared pin while its enable is high
  assign t_pin_in = t_pin_oe ? t_pin_out : t_drive;
endmodule : teiu_pin_src

// ---- dv/teiu_tb.sv ----
// Purpose: Self-checking bench for the timer, event and interrupt unit
// Assumes: Short long-prescaler period keeps timer runs brief
// Notes: Scenarios share state and must run in the given order
`timescale 1ns/100ps
`include "teiu_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  localparam int PRESC = 20;
  localparam int S_ALLOW = 0, S_BLOCK = 1, S_IRET = 2, S_CALL = 3, S_RET = 4;
  localparam int S_VWR = 5, S_WWR = 6, S_LD1 = 7, S_RD1 = 8, S_RD2 = 9;
  localparam int S_LDR = 10, S_RDR = 11, S_SK1 = 12, S_SK2 = 13;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic [13:0] strb = 14'h0000;
  logic [7:0] dat = 8'h00;
  logic ext_req = 1'h0;
  logic t_req = 1'h0;
  logic irq_pin, t_pin_in, rd_valid, skip_result, irq_taken, return_valid;
  logic irq_allow_flag, t_pin_out, t_pin_oe;
  logic [7:0] rd_data;
  logic [10:0] irq_vector, return_pc;
  logic [1:0] skip_state_out, stack_depth;
  int errors = 0;
  int n_compared = 0;

  always #25 mclk = ~mclk;

  teiu_pin_src #(.HOLD(4)) pin_u (.mclk(mclk), .ext_req(ext_req), .t_req(t_req),
    .t_pin_oe(t_pin_oe), .t_pin_out(t_pin_out), .irq_pin(irq_pin), .t_pin_in(t_pin_in));

  teiu_top #(.PRESC_LONG_CYC(PRESC)) dut_u (.mclk(mclk), .reset_n(reset_n),
    .irq_pin(irq_pin), .t_pin_in(t_pin_in), .irq_allow_instruction(strb[S_ALLOW]),
    .irq_block_instruction(strb[S_BLOCK]), .irq_return_instruction(strb[S_IRET]),
    .call_instr(strb[S_CALL]), .ret_instr(strb[S_RET]), .pc_in({3'h0, dat}),
    .skip_state_in(dat[1:0]), .ctl_v_write(strb[S_VWR]), .ctl_w_write(strb[S_WWR]),
    .ctl_data(dat[3:0]), .ab_in(dat), .load_first_timer(strb[S_LD1]),
    .read_first_timer(strb[S_RD1]), .read_second_timer(strb[S_RD2]),
    .load_reload_value(strb[S_LDR]), .read_reload_value(strb[S_RDR]),
    .skip_on_first_overflow(strb[S_SK1]), .skip_on_second_overflow(strb[S_SK2]),
    .rd_data(rd_data), .rd_valid(rd_valid), .skip_result(skip_result),
    .irq_taken(irq_taken), .irq_vector(irq_vector), .return_pc(return_pc),
    .return_valid(return_valid), .skip_state_out(skip_state_out),
    .stack_depth(stack_depth), .irq_allow_flag(irq_allow_flag),
    .t_pin_out(t_pin_out), .t_pin_oe(t_pin_oe));

  // One-cycle strobe; returns just after the edge that answers it
  task automatic instr(input int idx, input logic [7:0] d);
    @(posedge mclk);
    strb[idx] <= 1'h1;
    dat <= d;
    @(posedge mclk);
    strb[idx] <= 1'h0;
    #1;
  endtask : instr

  task automatic pin_pulse(input int sel);
    @(posedge mclk);
    if (sel == 0) ext_req <= 1'h1; else t_req <= 1'h1;
    @(posedge mclk);
    ext_req <= 1'h0;
    t_req <= 1'h0;
    repeat (10) @(posedge mclk);
  endtask : pin_pulse

  // Cycles until irq_taken (sel 0) or t_pin_out (sel 1), -1 if never
  task automatic wait_sig(input int sel, input int max, output int n);
    bit hit;
    n = 0;
    hit = 0;
    while (!hit && n < max) begin
      @(posedge mclk);
      #1;
      n++;
      hit = (sel == 0) ? (irq_taken === 1'h1) : (t_pin_out === 1'h1);
    end
    if (!hit) n = -1;
  endtask : wait_sig

  // Timer 2 model: wraps to the reload value after all ones
  function automatic logic [7:0] adv(input logic [7:0] c, input int k);
    for (int i = 0; i < k; i++) c = (c == 8'hFF) ? 8'hFE : c + 8'h01;
    return c;
  endfunction : adv

  task automatic t_reset;
    #1;
    `CHK("allow flag", 1'h0, irq_allow_flag)
    `CHK("pin enable", 1'h1, t_pin_oe)
    `CHK("pin level", 1'h0, t_pin_out)
    `CHK("depth", 2'h0, stack_depth)
  endtask : t_reset

  task automatic t_stack;
    for (int i = 1; i <= 4; i++) instr(S_CALL, i[7:0]);
    `CHK("full depth", `TEIU_STACK_DEPTH, stack_depth)
    for (int i = 0; i < 3; i++) begin
      instr(S_RET, 8'h00);
      `CHK("popped pc", 11'(4 - i), return_pc)
    end
    `CHK("empty depth", 2'h0, stack_depth)
  endtask : t_stack

  task automatic t_regs;
    instr(S_LD1, 8'hA5);
    instr(S_RD1, 8'h00);
    `CHK("timer1 value", 8'hA5, rd_data)
    `CHK("read valid", 1'h1, rd_valid)
    instr(S_LDR, 8'h3C);
    instr(S_RDR, 8'h00);
    `CHK("reload value", 8'h3C, rd_data)
  endtask : t_regs

  task automatic t_timer2;
    int n;
    instr(S_LDR, 8'hFE);
    instr(S_WWR, 8'h04);
    instr(S_VWR, 8'h02);
    wait_sig(1, 300 * PRESC, n);
    `CHK("overflow pulse", 1'h1, n > 0)
    instr(S_RD2, 8'h00);
    `CHK("timer2 reloaded", 8'hFE, rd_data)
    instr(S_SK2, 8'h00);
    `CHK("polled flag", 1'h1, skip_result)
    instr(S_SK2, 8'h00);
    `CHK("flag cleared", 1'h0, skip_result)
    instr(S_RDR, 8'h00);
    `CHK("reload kept", 8'hFE, rd_data)
    wait_sig(1, 100, n);
    wait_sig(1, 100, n);
    `CHK("overflow spacing", 2 * PRESC, n)
  endtask : t_timer2

  task automatic t_timer1;
    int n;
    instr(S_LD1, 8'hFE);
    instr(S_WWR, 8'h05);
    instr(S_VWR, 8'h07);
    wait_sig(0, 200, n);
    `CHK("held while blocked", -1, n)
    instr(S_RD1, 8'h00);
    `CHK("timer1 halted", 8'h00, rd_data)
    instr(S_ALLOW, 8'h5A);
    wait_sig(0, 5, n);
    `CHK("pending taken", 1'h1, n > 0)
    `CHK("timer1 vector", `TEIU_VEC_T1, irq_vector)
    `CHK("allow cleared", 1'h0, irq_allow_flag)
    `CHK("pc pushed", 2'h1, stack_depth)
    instr(S_IRET, 8'h00);
    `CHK("return valid", 1'h1, return_valid)
    `CHK("return pc", 11'h05A, return_pc)
    `CHK("skip restored", 2'h2, skip_state_out)
    `CHK("allow stays clear", 1'h0, irq_allow_flag)
    instr(S_SK1, 8'h00);
    `CHK("flag consumed", 1'h0, skip_result)
    instr(S_VWR, 8'h00);
  endtask : t_timer1

  task automatic t_ext;
    int n;
    instr(S_ALLOW, 8'h00);
    `CHK("allow set", 1'h1, irq_allow_flag)
    instr(S_BLOCK, 8'h00);
    `CHK("allow blocked", 1'h0, irq_allow_flag)
    pin_pulse(0);
    wait_sig(0, 20, n);
    `CHK("no take blocked", -1, n)
    instr(S_ALLOW, 8'h33);
    wait_sig(0, 5, n);
    `CHK("edge taken", 1'h1, n > 0)
    `CHK("ext vector", `TEIU_VEC_EXT, irq_vector)
    instr(S_IRET, 8'h00);
    `CHK("ext return pc", 11'h033, return_pc)
    `CHK("ext skip state", 2'h3, skip_state_out)
  endtask : t_ext

  // Timer 2 interrupt path and timer 1 on the prescaler, polled
  task automatic t_t2irq;
    int n;
    instr(S_LD1, 8'hFE);
    instr(S_WWR, 8'h04);
    instr(S_VWR, 8'h0B);
    instr(S_ALLOW, 8'h44);
    wait_sig(0, 100, n);
    `CHK("t2 irq taken", 1'h1, n > 0)
    `CHK("timer2 vector", `TEIU_VEC_T2, irq_vector)
    instr(S_IRET, 8'h00);
    `CHK("t2 return pc", 11'h044, return_pc)
    `CHK("t2 skip state", 2'h0, skip_state_out)
    repeat (60) @(posedge mclk);
    instr(S_SK1, 8'h00);
    `CHK("polled timer1", 1'h1, skip_result)
    instr(S_VWR, 8'h00);
  endtask : t_t2irq

  task automatic t_gate;
    logic [7:0] base;
    instr(S_WWR, 8'h0A);
    instr(S_VWR, 8'h01);
    `CHK("pin released", 1'h0, t_pin_oe)
    instr(S_RD2, 8'h00);
    base = rd_data;
    repeat (3) pin_pulse(1);
    instr(S_RD2, 8'h00);
    `CHK("gated count", adv(base, 3), rd_data)
    instr(S_WWR, 8'h02);
    repeat (3) pin_pulse(1);
    instr(S_RD2, 8'h00);
    `CHK("gate closed", adv(base, 3), rd_data)
    instr(S_VWR, 8'h02);
    pin_pulse(1);
    instr(S_RD2, 8'h00);
    `CHK("pin count", adv(base, 4), rd_data)
  endtask : t_gate

  task automatic finish_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    t_reset();
    t_stack();
    t_regs();
    t_timer2();
    t_timer1();
    t_ext();
    t_t2irq();
    t_gate();
    finish_test();
  end

  // Longest wait is one timer 2 lap; this leaves ample margin
  initial begin
    #(50 * 20000);
    errors++;
    finish_test();
  end
endmodule : testbench
